// *** verilog/wtrc_pkg.sv ***
// Package of constants and types for the transmit access, rate and retry control block
package wtrc_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CW = 4'h1;
    localparam logic [3:0] REG_MOD = 4'h2;
    localparam logic [3:0] REG_SNR = 4'h3;
    localparam logic [3:0] REG_RETRY = 4'h4;
    localparam logic [3:0] REG_BURST = 4'h5;
    localparam logic [3:0] REG_STATUS = 4'h6;
    localparam logic [3:0] REG_SUBBAND = 4'h7;
    // CTRL bits
    localparam int CTRL_ADAPT = 0;
    localparam int CTRL_ACK_L1 = 1;
    localparam int CTRL_PRIO = 2;
    localparam int CTRL_BURST = 3;
    localparam int CTRL_DFS = 4;
    localparam int CTRL_WEP = 5;
    localparam int CTRL_OLD_REV = 6;
    localparam int CTRL_IS_BASE = 7;
    localparam logic [7:0] CTRL_RST = 8'h09;
    localparam logic [2:0] CW_MIN_RST = 3'h1;
    localparam logic [2:0] CW_MAX_RST = 3'h7;
    localparam logic [3:0] MCAST_RST = 4'h1;
    localparam logic [3:0] LVL_TOP = 4'h8;
    localparam logic [3:0] LVL_LOW = 4'h1;
    localparam logic [3:0] ACK_MID = 4'h3;
    localparam logic [3:0] ACK_HIGH = 4'h5;
    localparam logic [5:0] MEM_RST = 6'h05;
    localparam logic [5:0] MEM_NONE = 6'h3f;
    localparam logic [5:0] MEM_MAX = 6'h20;
    localparam logic [3:0] RETRY_RST = 4'ha;
    localparam logic [3:0] RETRY_MIN = 4'h1;
    localparam logic [3:0] RETRY_MAX = 4'he;
    localparam int CLK_MHZ = 100;
    localparam int SIFS_US = 16;
    localparam int SIFS_CYC = SIFS_US * CLK_MHZ;
    localparam int AIFS_SLOTS = 2;
    localparam int SLOT_US = 9;
    localparam int SLOT_CYC = SLOT_US * CLK_MHZ;
    localparam int BURST_DEF_MS = 5;
    localparam logic [15:0] BURST_DEF_100US = 16'(BURST_DEF_MS * 10);
    localparam int TICK_US = 100;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam logic [15:0] LFSR_SEED = 16'hace1;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SPACE = 3'b001,
        ST_BACKOFF = 3'b010,
        ST_TX = 3'b011,
        ST_WAIT_ACK = 3'b100
    } wtrc_state_t;
    typedef enum logic [1:0] {
        FR_UNICAST = 2'b00,
        FR_MCAST = 2'b01,
        FR_MGMT = 2'b10,
        FR_ACK = 2'b11
    } wtrc_frame_t;
endpackage : wtrc_pkg

// *** verilog/wtrc_ctrl.sv ***
// Transmit access, modulation choice, retry, burst and SNR averaging control
`timescale 1ns/1ns
`default_nettype none
module wtrc_ctrl #(
    parameter int SPACE_CYC = wtrc_pkg::SIFS_CYC,
    parameter int SLOT_CYCLES = wtrc_pkg::SLOT_CYC,
    parameter int TICK_CYCLES = wtrc_pkg::TICK_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [wtrc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic [3:0] subband_max_lvl,
    input wire logic [3:0] subband_min_lvl,
    input wire logic subband_burst_ok,
    input wire logic [15:0] subband_burst_max,
    input wire logic tx_req,
    input wire wtrc_pkg::wtrc_frame_t tx_type,
    input wire logic [3:0] adapt_lvl,
    input wire logic [3:0] rx_lvl,
    input wire logic ack_needed,
    input wire logic medium_busy,
    input wire logic tx_done,
    input wire logic ack_ok,
    input wire logic ack_fail,
    input wire logic collision,
    input wire logic snr_valid,
    input wire logic [7:0] snr_sample,
    output logic tx_start,
    output logic [3:0] tx_lvl,
    output logic frame_drop,
    output logic frame_done,
    output logic ack_start,
    output logic [3:0] ack_lvl,
    output logic [7:0] snr_avg,
    output logic burst_active
);
    import wtrc_pkg::*;

    typedef struct packed {
        wtrc_state_t st;
        logic [7:0] ctrl;
        logic [2:0] cw_min;
        logic [2:0] cw_max;
        logic [2:0] cw_idx;
        logic [3:0] max_lvl;
        logic [3:0] mc_lvl;
        logic [5:0] mem;
        logic [3:0] retry_lim;
        logic [15:0] burst_ivl;
        logic [3:0] retries;
        logic [9:0] slots;
        logic [15:0] cyc;
        logic [15:0] tick;
        logic [15:0] burst_left;
        logic [15:0] lfsr;
        wtrc_frame_t ftype;
        logic busy_s1;
        logic busy_s2;
        logic [31:0] rdata;
        logic tx_start;
        logic [3:0] tx_lvl;
        logic frame_drop;
        logic frame_done;
        logic ack_start;
        logic [3:0] ack_lvl;
        logic [7:0] snr_avg;
        logic burst;
        logic [15:0] drops;
    } wtrc_regs_t;

    wtrc_regs_t r_reg, r_next;

    // Bound 2^(idx+3)-1: 7..1023
    function automatic logic [9:0] cw_val(input logic [2:0] idx);
        cw_val = 10'((11'h8 << idx) - 11'h1);
    endfunction : cw_val

    function automatic logic [3:0] clamp_lvl(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
        clamp_lvl = (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction : clamp_lvl

    // Old units block burst with DFS (base only) or encryption
    function automatic logic burst_blocked(input logic [7:0] c);
        burst_blocked = c[CTRL_OLD_REV] && ((c[CTRL_IS_BASE] && c[CTRL_DFS]) || c[CTRL_WEP]);
    endfunction : burst_blocked

    logic burst_allowed;
    logic [3:0] data_lvl;
    logic [3:0] top_lvl;
    logic [3:0] rx_ack_lvl;
    logic [15:0] burst_def;
    logic [15:0] sum;
    logic [6:0] div;
    logic retry_unlimited;

    always_comb begin
        burst_allowed = r_reg.ctrl[CTRL_BURST] && subband_burst_ok && !r_reg.ctrl[CTRL_PRIO]
            && !burst_blocked(r_reg.ctrl);
        // Reset value 8 is cut to what the sub-band offers
        top_lvl = clamp_lvl(r_reg.max_lvl, subband_min_lvl, subband_max_lvl);
        data_lvl = r_reg.ctrl[CTRL_ADAPT]
            ? clamp_lvl(adapt_lvl, subband_min_lvl, top_lvl)
            : top_lvl;
        if (r_reg.ctrl[CTRL_ACK_L1]) begin
            rx_ack_lvl = LVL_LOW;
        end else if (rx_lvl <= 4'h2) begin
            rx_ack_lvl = LVL_LOW;
        end else if (rx_lvl <= 4'h4) begin
            rx_ack_lvl = ACK_MID;
        end else begin
            rx_ack_lvl = ACK_HIGH;
        end
        // Defaults bounded by sub-band once it is known
        burst_def = (r_reg.burst_ivl > subband_burst_max) ? subband_burst_max : r_reg.burst_ivl;
        retry_unlimited = r_reg.ctrl[CTRL_PRIO] || r_reg.ctrl[CTRL_ADAPT];
        div = 7'(r_reg.mem) + 7'h1;
        sum = 16'(r_reg.snr_avg) * 16'(r_reg.mem) + 16'(snr_sample);
    end

    always_comb begin
        r_next = r_reg;
        r_next.tx_start = 1'b0;
        r_next.frame_drop = 1'b0;
        r_next.frame_done = 1'b0;
        r_next.ack_start = 1'b0;
        r_next.busy_s1 = medium_busy;
        r_next.busy_s2 = r_reg.busy_s1;
        r_next.lfsr = {r_reg.lfsr[14:0], r_reg.lfsr[15] ^ r_reg.lfsr[14] ^ r_reg.lfsr[12] ^ r_reg.lfsr[3]};
        r_next.rdata = 32'h0;

        // Register reads
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL: r_next.rdata = {24'h0, r_reg.ctrl};
                REG_CW: r_next.rdata = {14'h0, cw_val(r_reg.cw_idx), 8'h0} | {26'h0, r_reg.cw_max, r_reg.cw_min};
                REG_MOD: r_next.rdata = {24'h0, r_reg.mc_lvl, r_reg.max_lvl};
                REG_SNR: r_next.rdata = {16'h0, r_reg.snr_avg, 2'h0, r_reg.mem};
                REG_RETRY: r_next.rdata = {16'h0, r_reg.drops[11:0], r_reg.retry_lim};
                REG_BURST: r_next.rdata = {r_reg.burst_left, r_reg.burst_ivl};
                REG_STATUS: r_next.rdata = {22'h0, burst_allowed, r_reg.burst, r_reg.retries, 1'b0, r_reg.st};
                default: r_next.rdata = 32'h0;
            endcase
        end

        // Register writes, out-of-range values clamped
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: begin
                    // Enable refused rather than latched while blocked
                    r_next.ctrl = reg_wdata[7:0];
                    r_next.ctrl[CTRL_BURST] = reg_wdata[CTRL_BURST] && !burst_blocked(reg_wdata[7:0]);
                end
                REG_CW: begin
                    r_next.cw_min = reg_wdata[2:0];
                    r_next.cw_max = reg_wdata[5:3];
                end
                REG_MOD: begin
                    r_next.max_lvl = clamp_lvl(reg_wdata[3:0], subband_min_lvl, subband_max_lvl);
                    r_next.mc_lvl = clamp_lvl(reg_wdata[7:4], subband_min_lvl, subband_max_lvl);
                end
                REG_SNR: r_next.mem = (reg_wdata[5:0] == MEM_NONE || reg_wdata[5:0] <= MEM_MAX)
                    ? reg_wdata[5:0] : MEM_MAX;
                REG_RETRY: r_next.retry_lim = (reg_wdata[3:0] < RETRY_MIN) ? RETRY_MIN
                    : ((reg_wdata[3:0] > RETRY_MAX) ? RETRY_MAX : reg_wdata[3:0]);
                REG_BURST: r_next.burst_ivl = (reg_wdata[15:0] == 16'h0) ? 16'h1
                    : ((reg_wdata[15:0] > subband_burst_max) ? subband_burst_max : reg_wdata[15:0]);
                REG_SUBBAND: r_next.max_lvl = subband_max_lvl;
                default: ;
            endcase
        end

        // SNR running average
        if (snr_valid) begin
            if (r_reg.mem == MEM_NONE) begin
                r_next.snr_avg = snr_sample;
            end else begin
                r_next.snr_avg = 8'(sum / 16'(div));
            end
        end

        // Ack answers to received frames
        if (ack_needed) begin
            r_next.ack_start = 1'b1;
            r_next.ack_lvl = rx_ack_lvl;
        end

        // Burst interval in 100 us ticks
        if (r_reg.burst) begin
            if (r_reg.tick == 16'(TICK_CYCLES - 1)) begin
                r_next.tick = 16'h0;
                if (r_reg.burst_left <= 16'h1) begin
                    r_next.burst = 1'b0;
                end else begin
                    r_next.burst_left = r_reg.burst_left - 16'h1;
                end
            end else begin
                r_next.tick = r_reg.tick + 16'h1;
            end
        end
        if (!burst_allowed) begin
            r_next.burst = 1'b0;
        end

        case (r_reg.st)
            ST_IDLE: begin
                if (tx_req) begin
                    r_next.ftype = tx_type;
                    r_next.retries = 4'h0;
                    r_next.cyc = 16'h0;
                    r_next.st = ST_SPACE;
                    if (burst_allowed && !r_reg.burst && tx_type == FR_UNICAST) begin
                        r_next.burst = 1'b1;
                        r_next.burst_left = burst_def;
                        r_next.tick = 16'h0;
                    end
                end
            end
            ST_SPACE: begin
                if (r_reg.busy_s2) begin
                    r_next.cyc = 16'h0;
                end else if (r_reg.burst && r_reg.ftype == FR_UNICAST) begin
                    if (r_reg.cyc >= 16'(SPACE_CYC - 1)) begin
                        r_next.st = ST_TX;
                    end else begin
                        r_next.cyc = r_reg.cyc + 16'h1;
                    end
                end else if (r_reg.cyc >= 16'(SPACE_CYC + AIFS_SLOTS * SLOT_CYCLES - 1)) begin
                    r_next.cyc = 16'h0;
                    r_next.slots = (r_reg.cw_min == 3'h0 && r_reg.cw_idx == 3'h0) ? 10'h0
                        : r_reg.lfsr[9:0] & cw_val(r_reg.cw_idx);
                    r_next.st = ST_BACKOFF;
                end else begin
                    r_next.cyc = r_reg.cyc + 16'h1;
                end
            end
            ST_BACKOFF: begin
                if (r_reg.slots == 10'h0) begin
                    r_next.st = ST_TX;
                end else if (!r_reg.busy_s2) begin
                    if (r_reg.cyc >= 16'(SLOT_CYCLES - 1)) begin
                        r_next.cyc = 16'h0;
                        r_next.slots = r_reg.slots - 10'h1;
                    end else begin
                        r_next.cyc = r_reg.cyc + 16'h1;
                    end
                end
            end
            ST_TX: begin
                r_next.tx_start = 1'b1;
                case (r_reg.ftype)
                    FR_MCAST: r_next.tx_lvl = r_reg.mc_lvl;
                    FR_MGMT, FR_ACK: r_next.tx_lvl = subband_min_lvl;
                    default: r_next.tx_lvl = data_lvl;
                endcase
                r_next.st = ST_WAIT_ACK;
            end
            ST_WAIT_ACK: begin
                if (collision && r_reg.ftype == FR_UNICAST) begin
                    r_next.cw_idx = (r_reg.cw_idx < r_reg.cw_max) ? r_reg.cw_idx + 3'h1 : r_reg.cw_max;
                    r_next.cyc = 16'h0;
                    r_next.st = ST_SPACE;
                end else if (r_reg.ftype != FR_UNICAST && tx_done) begin
                    r_next.frame_done = 1'b1;
                    r_next.st = ST_IDLE;
                end else if (ack_ok) begin
                    r_next.frame_done = 1'b1;
                    r_next.cw_idx = (r_reg.cw_min == 3'h0) ? 3'h0 : r_reg.cw_min - 3'h1;
                    r_next.st = ST_IDLE;
                end else if (ack_fail) begin
                    if (!retry_unlimited && r_reg.retries >= r_reg.retry_lim) begin
                        r_next.frame_drop = 1'b1;
                        r_next.drops = r_reg.drops + 16'h1;
                        r_next.st = ST_IDLE;
                    end else if (retry_unlimited && r_reg.ctrl[CTRL_ADAPT] && !r_reg.ctrl[CTRL_PRIO]
                                 && r_reg.retries >= r_reg.retry_lim) begin
                        r_next.frame_drop = 1'b1;
                        r_next.st = ST_IDLE;
                    end else begin
                        r_next.retries = r_reg.retries + 4'h1;
                        r_next.cyc = 16'h0;
                        r_next.st = ST_SPACE;
                    end
                end
            end
            default: r_next.st = ST_IDLE;
        endcase
        // Ceiling may be lowered at any time
        if (r_next.cw_idx > r_next.cw_max) begin
            r_next.cw_idx = r_next.cw_max;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.ctrl <= CTRL_RST;
            r_reg.cw_min <= CW_MIN_RST;
            r_reg.cw_max <= CW_MAX_RST;
            r_reg.cw_idx <= 3'h0;
            r_reg.max_lvl <= LVL_TOP;
            r_reg.mc_lvl <= MCAST_RST;
            r_reg.mem <= MEM_RST;
            r_reg.retry_lim <= RETRY_RST;
            r_reg.burst_ivl <= BURST_DEF_100US;
            r_reg.lfsr <= LFSR_SEED;
            r_reg.ftype <= FR_UNICAST;
            r_reg.tx_lvl <= LVL_LOW;
            r_reg.ack_lvl <= LVL_LOW;
        end else begin
            r_reg <= r_next;
        end
    end

    assign reg_rdata = r_reg.rdata;
    assign tx_start = r_reg.tx_start;
    assign tx_lvl = r_reg.tx_lvl;
    assign frame_drop = r_reg.frame_drop;
    assign frame_done = r_reg.frame_done;
    assign ack_start = r_reg.ack_start;
    assign ack_lvl = r_reg.ack_lvl;
    assign snr_avg = r_reg.snr_avg;
    assign burst_active = r_reg.burst;
endmodule : wtrc_ctrl
`default_nettype wire

// *** bench/wtrc_peer.sv ***
// Peer radio model answering each transmission
`timescale 1ns/1ns
`default_nettype none
module wtrc_peer (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic tx_start,
    input wire wtrc_pkg::wtrc_frame_t tx_type,
    input wire logic [1:0] resp,
    input wire logic [3:0] dly,
    output logic tx_done,
    output logic ack_ok,
    output logic ack_fail,
    output logic collision
);
    import wtrc_pkg::*;
    logic pend;
    logic [3:0] cnt;
    wtrc_frame_t kind;
    always_ff @(posedge core_clk) begin
        tx_done <= 1'b0;
        ack_ok <= 1'b0;
        ack_fail <= 1'b0;
        collision <= 1'b0;
        if (rst) begin
            pend <= 1'b0;
        end else if (tx_start) begin
            pend <= 1'b1;
            cnt <= dly;
            kind <= tx_type;
        end else if (pend && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else if (pend) begin
            pend <= 1'b0;
            // Group frames never draw an answer
            if (kind != FR_UNICAST) tx_done <= 1'b1;
            else if (resp == 2'h0) ack_ok <= 1'b1;
            else if (resp == 2'h1) ack_fail <= 1'b1;
            else collision <= 1'b1;
        end
    end
endmodule : wtrc_peer
`default_nettype wire

// *** bench/wtrc_chk.sv ***
// Port-level assertions for the transmit control block
`timescale 1ns/1ns
`default_nettype none
module wtrc_chk #(
    parameter int SPACE_CYC = 4
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [wtrc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic [3:0] subband_max_lvl,
    input wire logic [3:0] subband_min_lvl,
    input wire logic tx_req,
    input wire wtrc_pkg::wtrc_frame_t tx_type,
    input wire logic [3:0] rx_lvl,
    input wire logic ack_needed,
    input wire logic ack_fail,
    input wire logic snr_valid,
    input wire logic [7:0] snr_sample,
    input wire logic tx_start,
    input wire logic [3:0] tx_lvl,
    input wire logic frame_drop,
    input wire logic ack_start,
    input wire logic [3:0] ack_lvl,
    input wire logic [7:0] snr_avg,
    input wire logic burst_active
);
    import wtrc_pkg::*;
    logic [7:0] ctrl_sh;
    logic [5:0] mem_sh;
    logic [3:0] ack_exp;
    logic [7:0] avg_exp;
    int since_req;
    wtrc_frame_t kind_l;
    // Shadows follow writes so expectations need no peek inside
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_sh <= CTRL_RST;
            mem_sh <= MEM_RST;
            since_req <= 0;
            kind_l <= FR_UNICAST;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL) ctrl_sh <= reg_wdata[7:0];
            if (reg_wr && reg_addr == REG_SNR) mem_sh <= (reg_wdata[5:0] > MEM_MAX && reg_wdata[5:0] != MEM_NONE) ?
                MEM_MAX : reg_wdata[5:0];
            since_req <= tx_req ? 1 : (since_req < 1000 ? since_req + 1 : since_req);
            if (tx_req) kind_l <= tx_type;
        end
    end
    always_comb begin
        ack_exp = (ctrl_sh[CTRL_ACK_L1] || rx_lvl <= 4'h2) ? LVL_LOW : (rx_lvl <= 4'h4 ? ACK_MID : ACK_HIGH);
        avg_exp = mem_sh == MEM_NONE ? snr_sample :
            8'((32'(snr_avg) * 32'(mem_sh) + 32'(snr_sample)) / (32'(mem_sh) + 32'h1));
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_ack_level_map: assert property (ack_needed |=> ack_start && ack_lvl == $past(ack_exp))
        else $error("ack level wrong");
    a_snr_average: assert property (snr_valid |=> snr_avg == $past(avg_exp))
        else $error("snr average wrong");
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_tx_level_cap: assert property (tx_start |-> tx_lvl <= subband_max_lvl && tx_lvl >= subband_min_lvl)
        else $error("tx level out of range");
    a_mgmt_low_level: assert property (tx_start && kind_l == FR_MGMT |-> tx_lvl == subband_min_lvl)
        else $error("management level wrong");
    a_drop_cause: assert property (frame_drop |-> $past(ack_fail))
        else $error("drop without failed answer");
    a_spacing_min: assert property (tx_start |-> since_req >= SPACE_CYC)
        else $error("start before spacing");
    a_prio_no_burst: assert property (ctrl_sh[CTRL_PRIO] && $past(ctrl_sh[CTRL_PRIO], 2) |-> !burst_active)
        else $error("burst under prioritization");
    c_drop: cover property (frame_drop);
    c_burst: cover property ($rose(burst_active));
    c_ack_high: cover property (ack_start && ack_lvl == ACK_HIGH);
endmodule : wtrc_chk
bind wtrc_ctrl wtrc_chk #(.SPACE_CYC(SPACE_CYC)) u_chk (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .subband_max_lvl(subband_max_lvl), .subband_min_lvl(subband_min_lvl), .tx_req(tx_req), .tx_type(tx_type),
    .rx_lvl(rx_lvl), .ack_needed(ack_needed), .ack_fail(ack_fail), .snr_valid(snr_valid),
    .snr_sample(snr_sample), .tx_start(tx_start), .tx_lvl(tx_lvl), .frame_drop(frame_drop),
    .ack_start(ack_start), .ack_lvl(ack_lvl), .snr_avg(snr_avg), .burst_active(burst_active));
`default_nettype wire

// *** bench/wtrc_ctrl_test.sv ***
// Self-checking bench for the transmit control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module wtrc_ctrl_test;
    import wtrc_pkg::*;
    typedef struct { logic [1:0] op; logic [3:0] a; logic [31:0] b; logic [31:0] m; logic [31:0] e; } wtrc_row_t;
    wtrc_row_t rows [21];
    logic core_clk, rst, reg_wr, reg_rd, subband_burst_ok, tx_req, ack_needed, medium_busy, snr_valid, dr, bs;
    logic tx_done, ack_ok, ack_fail, collision, tx_start, frame_drop, frame_done, ack_start, burst_active;
    logic [3:0] reg_addr, subband_max_lvl, subband_min_lvl, adapt_lvl, rx_lvl, tx_lvl, ack_lvl, lvl, dly;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [15:0] subband_burst_max;
    logic [7:0] snr_sample, snr_avg;
    logic [1:0] resp;
    wtrc_frame_t tx_type;
    int bad_count, checks_done, n, t;
    // Short timing parameters keep the run brief
    wtrc_ctrl #(.SPACE_CYC(4), .SLOT_CYCLES(2), .TICK_CYCLES(4)) dut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .subband_max_lvl(subband_max_lvl), .subband_min_lvl(subband_min_lvl), .subband_burst_ok(subband_burst_ok),
        .subband_burst_max(subband_burst_max), .tx_req(tx_req), .tx_type(tx_type), .adapt_lvl(adapt_lvl),
        .rx_lvl(rx_lvl), .ack_needed(ack_needed), .medium_busy(medium_busy), .tx_done(tx_done), .ack_ok(ack_ok),
        .ack_fail(ack_fail), .collision(collision), .snr_valid(snr_valid), .snr_sample(snr_sample),
        .tx_start(tx_start), .tx_lvl(tx_lvl), .frame_drop(frame_drop), .frame_done(frame_done),
        .ack_start(ack_start), .ack_lvl(ack_lvl), .snr_avg(snr_avg), .burst_active(burst_active));
    wtrc_peer peer (.core_clk(core_clk), .rst(rst), .tx_start(tx_start), .tx_type(tx_type), .resp(resp),
        .dly(dly), .tx_done(tx_done), .ack_ok(ack_ok), .ack_fail(ack_fail), .collision(collision));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task end_sim;
        $display("bad_count=%0d checks_done=%0d", bad_count, checks_done);
        if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        v = reg_rdata;
    endtask : rd
    task automatic snr(input logic [7:0] s);
        @(posedge core_clk);
        snr_valid <= 1'b1;
        snr_sample <= s;
        @(posedge core_clk);
        snr_valid <= 1'b0;
        @(negedge core_clk);
    endtask : snr
    task automatic rst_dut;
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
    endtask : rst_dut
    // Sends one frame; stops at its end or after maxn attempts
    task automatic xfer(input wtrc_frame_t ty, input int maxn);
        int k;
        logic fin;
        n = 0;
        t = 0;
        dr = 1'b0;
        bs = 1'b0;
        fin = 1'b0;
        @(posedge core_clk);
        tx_req <= 1'b1;
        tx_type <= ty;
        adapt_lvl <= 4'h7;
        @(posedge core_clk);
        tx_req <= 1'b0;
        for (k = 1; k < 3000 && !fin && n < maxn; k++) begin
            @(negedge core_clk);
            bs = bs | (burst_active === 1'b1);
            if (tx_start === 1'b1) begin
                n++;
                lvl = tx_lvl;
                if (n == 1) t = k;
            end
            fin = (frame_done === 1'b1) || (frame_drop === 1'b1);
            dr = (frame_drop === 1'b1);
        end
        if (!fin && n < maxn) begin
            bad_count++;
            end_sim();
        end
    endtask : xfer
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, tx_req, ack_needed, medium_busy, snr_valid} = 6'h0;
        {reg_addr, adapt_lvl, rx_lvl, reg_wdata, snr_sample} = 52'h0;
        {subband_max_lvl, subband_min_lvl, subband_burst_ok, subband_burst_max} = {4'h8, 4'h1, 1'b1, 16'h0064};
        tx_type = FR_UNICAST;
        resp = 2'h0;
        dly = 4'h2;
        rows = '{'{2'h0, REG_CTRL, 32'h0, 32'hff, 32'h09}, '{2'h0, REG_MOD, 32'h0, 32'hff, 32'h18},
            '{2'h0, REG_SNR, 32'h0, 32'h3f, 32'h05}, '{2'h0, REG_RETRY, 32'h0, 32'hf, 32'ha},
            '{2'h0, REG_BURST, 32'h0, 32'hffff, 32'h32}, '{2'h0, REG_CW, 32'h0, 32'h3f, 32'h39},
            '{2'h0, 4'hf, 32'h0, 32'hffffffff, 32'h0}, '{2'h1, REG_CTRL, 32'h68, 32'h8, 32'h0},
            '{2'h1, REG_CTRL, 32'h28, 32'h8, 32'h8}, '{2'h1, REG_CTRL, 32'hd8, 32'h8, 32'h0},
            '{2'h1, REG_CTRL, 32'h98, 32'h8, 32'h8}, '{2'h1, REG_CTRL, 32'h58, 32'h8, 32'h8},
            '{2'h1, REG_RETRY, 32'he, 32'hf, 32'he}, '{2'h2, 4'h1, 32'h09, 32'h0, 32'h1},
            '{2'h2, 4'h2, 32'h09, 32'h0, 32'h1}, '{2'h2, 4'h3, 32'h09, 32'h0, 32'h3},
            '{2'h2, 4'h4, 32'h09, 32'h0, 32'h3}, '{2'h2, 4'h5, 32'h09, 32'h0, 32'h5},
            '{2'h2, 4'h8, 32'h09, 32'h0, 32'h5}, '{2'h2, 4'h8, 32'h0b, 32'h0, 32'h1},
            '{2'h2, 4'h4, 32'h0b, 32'h0, 32'h1}};
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            if (rows[i].op == 2'h2) begin
                wr(REG_CTRL, rows[i].b);
                @(posedge core_clk);
                ack_needed <= 1'b1;
                rx_lvl <= rows[i].a;
                @(posedge core_clk);
                ack_needed <= 1'b0;
                @(negedge core_clk);
                `CHK({ack_start, ack_lvl}, {1'b1, rows[i].e[3:0]})
            end else begin
                if (rows[i].op == 2'h1) wr(rows[i].a, rows[i].b);
                rd(rows[i].a, d);
                `CHK(d & rows[i].m, rows[i].e)
            end
        end
        wr(REG_SNR, 32'h3f);
        snr(8'h64);
        `CHK(snr_avg, 8'h64)
        wr(REG_SNR, 32'h5);
        snr(8'h28);
        `CHK(snr_avg, 8'h5a)
        rd(REG_SNR, d);
        `CHK(d[15:8], 8'h5a)
        wr(REG_CTRL, 32'h0);
        wr(REG_MOD, 32'h34);
        wr(REG_RETRY, 32'h2);
        resp <= 2'h1;
        xfer(FR_UNICAST, 9);
        `CHK({lvl, dr, t >= 8}, {4'h4, 1'b1, 1'b1})
        `CHK(n, 3)
        dly <= 4'h9;
        xfer(FR_MCAST, 9);
        `CHK({lvl, dr, n == 1}, {4'h3, 1'b0, 1'b1})
        xfer(FR_MGMT, 9);
        `CHK(lvl, 4'h1)
        dly <= 4'h2;
        resp <= 2'h0;
        wr(REG_CTRL, 32'h1);
        xfer(FR_UNICAST, 9);
        `CHK(lvl, 4'h4)
        wr(REG_CTRL, 32'h8);
        wr(REG_BURST, 32'h2);
        xfer(FR_UNICAST, 9);
        `CHK({bs, t < 8}, 2'h3)
        for (n = 0; burst_active !== 1'b0 && n < 200; n++) @(negedge core_clk);
        `CHK(n < 200, 1'b1)
        if (n >= 200) end_sim();
        @(posedge core_clk);
        subband_burst_ok <= 1'b0;
        rd(REG_STATUS, d);
        `CHK(d[9], 1'b0)
        @(posedge core_clk);
        subband_burst_ok <= 1'b1;
        wr(REG_CW, 32'h8);
        rd(REG_CW, d);
        `CHK(d[17:8], 10'h7)
        resp <= 2'h2;
        xfer(FR_UNICAST, 3);
        rd(REG_CW, d);
        `CHK(d[17:8], 10'hf)
        // Mid-run reset while the frame is still retrying
        rst_dut();
        rd(REG_CTRL, d);
        `CHK(d[7:0], 8'h09)
        wr(REG_CTRL, 32'hc);
        wr(REG_RETRY, 32'h1);
        resp <= 2'h1;
        xfer(FR_UNICAST, 5);
        `CHK({n == 5, dr, bs}, 3'h4)
        rst_dut();
        end_sim();
    end
endmodule : wtrc_ctrl_test
`default_nettype wire
